// ---- core_map_pkg.sv ----
// Constants for the table read path and data memory map.
// Behaviour
// R1: After reset the fetch address starts at program address zero.
// R2: A table fetch address is built from both table pointer bytes; the code uses only the low byte for the last-page read, with upper bits FH.
// R3: The high pointer gives the upper four bits, the low pointer the lower eight.
// R4: A table read writes the word's low byte into the operand's data location; the code writes it only to general storage (80H up).
// R5: The same table read overwrites the high byte holding register.
// R6: Standard table reads target sector 0, extended ones any other sector.
// R7: Every table instruction takes exactly two instruction cycles.
// R8: Software should avoid table reads in both main code and interrupt code.
// R9: Each sector holds registers below 80H and general storage from 80H up.
// R10: General storage is 256 bytes over sectors 0 and 1; sector 1 has one register at 40H.
// R11: The active sector is chosen by loading the memory pointers.
// R12: For indirect access the high pointer picks the sector, the low the offset.
// R13: Reads of unused register locations return zero.
// R14: Programming data moves both ways on one data line clocked by the programmer.
// R15: The debug link has a two-way data line and an input clock from the tool.
// R16: On the emulation part the shared pin functions are off, programming still works.
package core_map_pkg;
  localparam logic [11:0] reset_vector      = 12'h000;
  localparam int          pc_width          = 12;
  localparam logic [7:0]  gp_base           = 8'h80;
  localparam logic [7:0]  eeprom_ctrl_addr  = 8'h40;
  localparam logic [7:0]  table_ptr_lo_addr = 8'h07;
  localparam logic [7:0]  table_data_h_addr = 8'h08;
  localparam logic [7:0]  table_ptr_hi_addr = 8'h09;
  localparam logic [7:0]  ptr_offset_addr   = 8'h03;
  localparam logic [7:0]  ptr_sector_addr   = 8'h04;
  localparam logic [7:0]  byte_reset        = 8'h00;
  localparam logic [7:0]  unused_value      = 8'h00;
  localparam logic [1:0]  table_cycles      = 2'h2;
  localparam logic [3:0]  last_page         = 4'hf;

  typedef enum logic [1:0] {
    op_none,
    table_fetch_op,
    table_fetch_last_page_op,
    ext_table_fetch_op
  } table_cmd_t;
endpackage : core_map_pkg

// ---- pin_sync.sv ----
// Two flip-flop synchroniser for external pin levels.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int width = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [width-1:0] async_in,
  output var  logic [width-1:0] sync_out
);
  logic [width-1:0] stage1;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- table_read_core.sv ----
// Table read path, sectored data memory and programming/debug pin sharing.
`timescale 1ns/100ps
`default_nettype none
module table_read_core
  import core_map_pkg::*;
#(
  parameter int gp_depth = 256
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        instr_cycle,
  input  wire logic [1:0]  table_cmd,
  input  wire logic        table_ext,
  input  wire logic [7:0]  table_dest,
  input  wire logic        table_dest_sector,
  output logic             table_busy,
  output logic             table_done,
  output var  logic [11:0] prog_addr,
  input  wire logic [15:0] prog_word,
  output var  logic [11:0] fetch_pc,
  input  wire logic        fetch_advance,
  input  wire logic        mem_wr,
  input  wire logic        mem_rd,
  input  wire logic        mem_indirect,
  input  wire logic        mem_sector,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic [7:0]  mem_rdata,
  output var  logic        mem_rvalid,
  input  wire logic        emulation_mode,
  input  wire logic        prog_serial_io_in,
  input  wire logic        prog_serial_drive,
  input  wire logic        prog_serial_tx,
  output logic             prog_serial_io_out,
  output logic             prog_serial_io_oe,
  input  wire logic        prog_clock,
  output var  logic        prog_serial_rx,
  output var  logic        prog_clock_sync,
  input  wire logic        debug_serial_io_in,
  input  wire logic        debug_serial_drive,
  input  wire logic        debug_serial_tx,
  output logic             debug_serial_io_out,
  output logic             debug_serial_io_oe,
  input  wire logic        debug_clock_in,
  output var  logic        debug_serial_rx,
  output var  logic        debug_clock_sync,
  input  wire logic        port_out0,
  input  wire logic        port_oe0,
  input  wire logic        port_out2,
  input  wire logic        port_oe2,
  output logic [1:0]       port_in
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] gp_ram [gp_depth];
  logic [7:0] table_ptr_lo;
  logic [3:0] table_ptr_hi;
  logic [7:0] table_data_high;
  logic [7:0] eeprom_control_reg;
  logic [7:0] mem_pointer_offset;
  logic [7:0] mem_pointer_sector;
  logic [1:0] cyc_count;
  logic       last_page_sel;
  logic [8:0] dest_latch;
  logic [3:0] pin_sync_q;

  function automatic logic [7:0] gp_index(input logic sec,
                                          input logic [7:0] a);
    gp_index = {sec, a[6:0]};
  endfunction : gp_index

  function automatic logic is_gp(input logic [7:0] a);
    is_gp = (a >= gp_base);
  endfunction : is_gp

  // ****************************************************************
  // Effective data address
  // ****************************************************************
  logic       eff_sector;
  logic [7:0] eff_addr;
  // R11 pointers choose sector.
  // R12 high byte is sector.
  always_comb begin
    if (mem_indirect) begin
      eff_sector = mem_pointer_sector[0];
      eff_addr   = mem_pointer_offset;
    end else begin
      eff_sector = mem_sector;
      eff_addr   = mem_addr;
    end
  end

  // ****************************************************************
  // Table read sequencer
  // ****************************************************************
  logic start_ok;
  // R6 sector versus opcode.
  assign start_ok = (table_cmd != op_none) && (cyc_count == 2'h0)
                    && (table_ext == table_dest_sector);
  assign table_busy = (cyc_count != 2'h0);

  // R7 two instruction cycles.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_count     <= 2'h0;
      last_page_sel <= 1'b0;
      dest_latch    <= 9'h000;
    end else if (instr_cycle) begin
      if (start_ok) begin
        cyc_count     <= table_cycles - 2'h1;
        last_page_sel <= (table_cmd == table_fetch_last_page_op);
        dest_latch    <= {table_dest_sector, table_dest};
      end else if (cyc_count != 2'h0) begin
        cyc_count <= cyc_count - 2'h1;
      end
    end
  end

  logic finishing;
  assign finishing = instr_cycle && (cyc_count == 2'h1);
  assign table_done = finishing;

  // R2 both pointer bytes, low byte only for last-page reads.
  // R3 high gives upper bits.
  always_comb begin
    prog_addr = {last_page_sel ? last_page : table_ptr_hi, table_ptr_lo};
  end

  // R1 reset entry point.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fetch_pc <= reset_vector;
    end else if (fetch_advance) begin
      fetch_pc <= fetch_pc + 12'h001;
    end
  end

  // ****************************************************************
  // Special registers
  // ****************************************************************
  logic cpu_sfr_wr;
  assign cpu_sfr_wr = mem_wr && !is_gp(eff_addr);

  // R5 high byte to holding register.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      table_data_high <= byte_reset;
    end else if (finishing) begin
      table_data_high <= prog_word[15:8];
    end else if (cpu_sfr_wr && !eff_sector
                 && eff_addr == table_data_h_addr) begin
      table_data_high <= mem_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      table_ptr_lo       <= byte_reset;
      table_ptr_hi       <= 4'h0;
      mem_pointer_offset <= byte_reset;
      mem_pointer_sector <= byte_reset;
      eeprom_control_reg <= byte_reset;
    end else if (cpu_sfr_wr) begin
      if (!eff_sector) begin
        unique case (eff_addr)
          table_ptr_lo_addr: table_ptr_lo <= mem_wdata;
          table_ptr_hi_addr: table_ptr_hi <= mem_wdata[3:0];
          ptr_offset_addr:   mem_pointer_offset <= mem_wdata;
          ptr_sector_addr:   mem_pointer_sector <= mem_wdata;
          default: ;
        endcase
      // R10 sole sector 1 register.
      end else if (eff_addr == eeprom_ctrl_addr) begin
        eeprom_control_reg <= mem_wdata;
      end
    end
  end

  // ****************************************************************
  // General storage
  // ****************************************************************
  // R4 low byte to destination.
  // R9 upper half is storage.
  always_ff @(posedge ref_clk) begin
    if (finishing && is_gp(dest_latch[7:0])) begin
      gp_ram[gp_index(dest_latch[8], dest_latch[7:0])] <= prog_word[7:0];
    end else if (mem_wr && is_gp(eff_addr)) begin
      gp_ram[gp_index(eff_sector, eff_addr)] <= mem_wdata;
    end
  end

  // R13 unused reads as zero.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_rdata  <= unused_value;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= mem_rd;
      if (mem_rd) begin
        if (is_gp(eff_addr)) begin
          mem_rdata <= gp_ram[gp_index(eff_sector, eff_addr)];
        end else if (eff_sector) begin
          mem_rdata <= (eff_addr == eeprom_ctrl_addr) ? eeprom_control_reg
                                                      : unused_value;
        end else begin
          unique case (eff_addr)
            table_ptr_lo_addr: mem_rdata <= table_ptr_lo;
            table_data_h_addr: mem_rdata <= table_data_high;
            table_ptr_hi_addr: mem_rdata <= {4'h0, table_ptr_hi};
            ptr_offset_addr:   mem_rdata <= mem_pointer_offset;
            ptr_sector_addr:   mem_rdata <= mem_pointer_sector;
            default:           mem_rdata <= unused_value;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Programming and debug pins
  // ****************************************************************
  pin_sync #(
    .width (4)
  ) u_pin_sync (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in ({prog_serial_io_in, prog_clock,
                debug_serial_io_in, debug_clock_in}),
    .sync_out (pin_sync_q)
  );

  // R14 one data line, outside clock.
  // R15 debug clock is an input.
  always_comb begin
    prog_serial_rx   = pin_sync_q[3];
    prog_clock_sync  = pin_sync_q[2];
    debug_serial_rx  = pin_sync_q[1];
    debug_clock_sync = pin_sync_q[0];
  end

  // R16 shared functions off in emulation.
  logic prog_active;
  assign prog_active         = prog_serial_drive;
  assign prog_serial_io_out  = prog_active ? prog_serial_tx : port_out0;
  assign prog_serial_io_oe   = prog_active
                               || (!emulation_mode && port_oe0);
  assign debug_serial_io_out = debug_serial_tx;
  assign debug_serial_io_oe  = emulation_mode && debug_serial_drive
                               && !prog_active;
  assign port_in = emulation_mode ? 2'h0 : {pin_sync_q[2], pin_sync_q[3]};

  // ****************************************************************
  // Checks
  // ****************************************************************
  // R1 reset entry point.
  a_reset_vector: assert property (@(posedge ref_clk)
    $fell(srst) |-> fetch_pc == reset_vector) // R1
    else $error("fetch did not start at zero");
  // R7 two instruction cycles.
  a_two_cycles: assert property (@(posedge ref_clk) disable iff (srst)
    (instr_cycle && start_ok) |=> table_busy) // R7
    else $error("table read did not start");
  a_busy_holds: assert property (@(posedge ref_clk) disable iff (srst)
    (table_busy && !instr_cycle) |=> table_busy) // R7
    else $error("table read ended between boundaries");
  a_done_next: assert property (@(posedge ref_clk) disable iff (srst)
    (table_busy && instr_cycle) |-> table_done ##1 !table_busy) // R7
    else $error("table read not two cycles");
  // R5 high byte stored.
  a_high_byte: assert property (@(posedge ref_clk) disable iff (srst)
    finishing |=> table_data_high == $past(prog_word[15:8])) // R5
    else $error("high byte not stored");
  // R3 address layout.
  a_addr_form: assert property (@(posedge ref_clk) disable iff (srst)
    !last_page_sel |-> prog_addr[7:0] == table_ptr_lo
                       && prog_addr[11:8] == table_ptr_hi) // R3
    else $error("table address wrong");
  // R6 sector mismatch refused.
  a_sector_rule: assert property (@(posedge ref_clk) disable iff (srst)
    (instr_cycle && !table_busy && table_ext != table_dest_sector)
      |=> !table_busy) // R6
    else $error("mismatched table read accepted");
  // R13 unused reads zero.
  a_unused_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (mem_rd && eff_sector && !is_gp(eff_addr)
      && eff_addr != eeprom_ctrl_addr) |=> mem_rdata == unused_value) // R13
    else $error("unused location not zero");
  // R12 indirect sector.
  a_indirect_sel: assert property (@(posedge ref_clk) disable iff (srst)
    mem_indirect |-> eff_sector == mem_pointer_sector[0]
                     && eff_addr == mem_pointer_offset) // R12
    else $error("indirect address wrong");
  // R16 debug pin quiet outside emulation.
  a_debug_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    !emulation_mode |-> !debug_serial_io_oe) // R16
    else $error("debug pin driven outside emulation");
  a_shared_off: assert property (@(posedge ref_clk) disable iff (srst)
    emulation_mode |-> port_in == 2'h0) // R16
    else $error("shared input active in emulation");
  c_table_std: cover property (@(posedge ref_clk) disable iff (srst)
    table_done && !dest_latch[8]);
  c_table_ext: cover property (@(posedge ref_clk) disable iff (srst)
    table_done && dest_latch[8]);
  c_indirect_rd: cover property (@(posedge ref_clk) disable iff (srst)
    mem_rd && mem_indirect && eff_sector);
endmodule : table_read_core
`default_nettype wire

// ---- table_cpu_model.sv ----
// Sequencer and program memory model facing the table read core.
`timescale 1ns/100ps
`default_nettype none
module table_cpu_model (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [11:0] prog_addr,
  output var  logic        instr_cycle,
  output var  logic [15:0] prog_word
);
  logic [1:0] phase;

  // Four clocks form one instruction cycle, whose boundary lasts one clock.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase <= 2'h0;
      instr_cycle <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      instr_cycle <= (phase == 2'h3);
    end
  end

  // Program words are a fixed function of their address, so a wrong address
  // shows up in the low byte (bits 7:0), the high byte (bits 11:4) or both.
  always_comb begin
    prog_word = {prog_addr[11:4] ^ 8'hA5, prog_addr[7:0] ^ 8'h3C};
  end
endmodule : table_cpu_model
`default_nettype wire

// ---- table_read_core_test.sv ----
// Self-checking testbench for the table read core.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module table_read_core_test;
  import core_map_pkg::*;
  logic ref_clk = 0, srst = 1, table_ext = 0, table_dest_sector = 0;
  logic [1:0] table_cmd = 0;
  logic [7:0] table_dest = 0, mem_addr = 0, mem_wdata = 0, rd;
  logic mem_wr = 0, mem_rd = 0, mem_indirect = 0, mem_sector = 0;
  logic fetch_advance = 0, emulation_mode = 0, prog_clock = 0;
  logic prog_serial_drive = 0, prog_serial_tx = 0, tool_prog = 0;
  logic debug_serial_drive = 0, debug_serial_tx = 0, tool_dbg = 0;
  logic debug_clock_in = 0, port_out0 = 0, port_oe0 = 0;
  logic instr_cycle, table_busy, table_done, mem_rvalid, prog_serial_io_in;
  logic prog_serial_io_out, prog_serial_io_oe, prog_serial_rx, prog_clock_sync;
  logic debug_serial_io_in, debug_serial_io_out, debug_serial_io_oe;
  logic debug_serial_rx, debug_clock_sync;
  logic [1:0] port_in;
  logic [11:0] prog_addr, fetch_pc, got_addr;
  logic [15:0] prog_word;
  int error_cnt = 0, cmp_count = 0;

  always #5 ref_clk = ~ref_clk;
  // Pin levels combine the device drive with the tool's level.
  assign prog_serial_io_in = prog_serial_io_oe ? prog_serial_io_out : tool_prog;
  assign debug_serial_io_in = debug_serial_io_oe ? debug_serial_io_out : tool_dbg;

  table_read_core dut (.ref_clk(ref_clk), .srst(srst), .instr_cycle(instr_cycle),
    .table_cmd(table_cmd), .table_ext(table_ext), .table_dest(table_dest),
    .table_dest_sector(table_dest_sector), .table_busy(table_busy),
    .table_done(table_done), .prog_addr(prog_addr), .prog_word(prog_word),
    .fetch_pc(fetch_pc), .fetch_advance(fetch_advance), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_indirect(mem_indirect), .mem_sector(mem_sector),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(rd),
    .mem_rvalid(mem_rvalid), .emulation_mode(emulation_mode),
    .prog_serial_io_in(prog_serial_io_in),
    .prog_serial_drive(prog_serial_drive),
    .prog_serial_tx(prog_serial_tx), .prog_serial_io_out(prog_serial_io_out),
    .prog_serial_io_oe(prog_serial_io_oe), .prog_clock(prog_clock),
    .prog_serial_rx(prog_serial_rx), .prog_clock_sync(prog_clock_sync),
    .debug_serial_io_in(debug_serial_io_in),
    .debug_serial_drive(debug_serial_drive), .debug_serial_tx(debug_serial_tx),
    .debug_serial_io_out(debug_serial_io_out),
    .debug_serial_io_oe(debug_serial_io_oe), .debug_clock_in(debug_clock_in),
    .debug_serial_rx(debug_serial_rx), .debug_clock_sync(debug_clock_sync),
    .port_out0(port_out0), .port_oe0(port_oe0), .port_out2(1'b0),
    .port_oe2(1'b0), .port_in(port_in));

  table_cpu_model model (.ref_clk(ref_clk), .srst(srst), .prog_addr(prog_addr),
    .instr_cycle(instr_cycle), .prog_word(prog_word));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic mem_op(input logic wr, ind, sec, input logic [7:0] a, d);
    @(negedge ref_clk);
    {mem_wr, mem_rd, mem_indirect, mem_sector, mem_addr, mem_wdata} =
      {wr, ~wr, ind, sec, a, d};
    @(negedge ref_clk);
    {mem_wr, mem_rd} = 2'b00;
    for (int i = 0; !wr && mem_rvalid !== 1'b1; i++) begin
      if (i == 4) begin
        error_cnt++;
        end_sim();
      end
      @(negedge ref_clk);
    end
  endtask : mem_op

  // Issues one table read at an instruction boundary and waits for its end.
  task automatic table_op(input logic [1:0] cmd, input logic ext, sec,
                          input logic [7:0] dest, input logic expect_go);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (instr_cycle !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    if (instr_cycle !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    {table_cmd, table_ext, table_dest_sector, table_dest} = {cmd, ext, sec, dest};
    @(negedge ref_clk);
    table_cmd = 2'h0;
    `CHK("busy", expect_go, table_busy)
    n = 0;
    for (int i = 0; i < 12 && table_done !== 1'b1; i++) begin
      @(negedge ref_clk);
      n += (instr_cycle === 1'b1);
    end
    got_addr = prog_addr;
    `CHK("done", expect_go, table_done)
    if (expect_go && table_done !== 1'b1) end_sim();
    if (expect_go) `CHK("boundaries to done", 1, n)
  endtask : table_op

  task automatic check_table(input logic [1:0] cmd, input logic ext, sec,
                             input logic [7:0] dest, input logic [11:0] ea);
    table_op(cmd, ext, sec, dest, 1'b1);
    `CHK("table addr", ea, got_addr)
    mem_op(1'b0, 1'b0, sec, dest, 8'h00);
    `CHK("low byte", ea[7:0] ^ 8'h3C, rd)
    mem_op(1'b0, 1'b0, 1'b0, table_data_h_addr, 8'h00);
    `CHK("high byte", ea[11:4] ^ 8'hA5, rd)
  endtask : check_table

  task automatic t_reset;
    `CHK("pc at reset", reset_vector, fetch_pc)
    fetch_advance = 1'b1;
    repeat (3) @(negedge ref_clk);
    fetch_advance = 1'b0;
    `CHK("pc advance", 12'h003, fetch_pc)
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    `CHK("pc after reset", reset_vector, fetch_pc)
    $display("test reset done");
  endtask : t_reset

  task automatic t_table;
    mem_op(1'b1, 1'b0, 1'b0, table_ptr_lo_addr, 8'h06);
    mem_op(1'b1, 1'b0, 1'b0, table_ptr_hi_addr, 8'h0F);
    check_table(2'h1, 1'b0, 1'b0, 8'h80, 12'hF06);
    mem_op(1'b1, 1'b0, 1'b0, table_ptr_lo_addr, 8'h05);
    // Second read, after a low pointer write; the next starts only after the last ended.
    check_table(2'h1, 1'b0, 1'b0, 8'hFF, 12'hF05);
    mem_op(1'b1, 1'b0, 1'b0, table_ptr_hi_addr, 8'h03);
    check_table(2'h2, 1'b0, 1'b0, 8'h81, 12'hF05);
    check_table(2'h3, 1'b1, 1'b1, 8'h90, 12'h305);
    table_op(2'h1, 1'b0, 1'b1, 8'h91, 1'b0);
    table_op(2'h3, 1'b1, 1'b0, 8'h92, 1'b0);
    $display("test table done");
  endtask : t_table

  task automatic t_map;
    mem_op(1'b1, 1'b0, 1'b1, eeprom_ctrl_addr, 8'h5A);
    mem_op(1'b0, 1'b0, 1'b1, eeprom_ctrl_addr, 8'h00);
    `CHK("sector 1 register", 8'h5A, rd)
    mem_op(1'b1, 1'b0, 1'b1, 8'h41, 8'hC3);
    mem_op(1'b0, 1'b0, 1'b1, 8'h41, 8'h00);
    `CHK("sector 1 unused", unused_value, rd)
    mem_op(1'b1, 1'b0, 1'b0, 8'h70, 8'hC3);
    mem_op(1'b0, 1'b0, 1'b0, 8'h70, 8'h00);
    `CHK("sector 0 unused", unused_value, rd)
    mem_op(1'b1, 1'b0, 1'b0, 8'hFE, 8'h96);
    mem_op(1'b1, 1'b0, 1'b1, 8'hFE, 8'h69);
    mem_op(1'b0, 1'b0, 1'b0, 8'hFE, 8'h00);
    `CHK("sector 0 storage", 8'h96, rd)
    mem_op(1'b1, 1'b0, 1'b0, ptr_sector_addr, 8'h01);
    mem_op(1'b1, 1'b0, 1'b0, ptr_offset_addr, 8'hFE);
    mem_op(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    `CHK("indirect read", 8'h69, rd)
    mem_op(1'b1, 1'b0, 1'b0, ptr_sector_addr, 8'h00);
    mem_op(1'b1, 1'b1, 1'b1, 8'h00, 8'h3A);
    mem_op(1'b0, 1'b0, 1'b0, 8'hFE, 8'h00);
    `CHK("indirect write", 8'h3A, rd)
    $display("test map done");
  endtask : t_map

  task automatic t_pins;
    {prog_serial_drive, prog_serial_tx} = 2'b10;
    {debug_serial_drive, debug_serial_tx} = 2'b11;
    repeat (2) @(negedge ref_clk);
    `CHK("prog drive", 2'b10, {prog_serial_io_oe, prog_serial_io_out})
    `CHK("debug quiet", 2'b01, {debug_serial_io_oe, debug_serial_io_out})
    emulation_mode = 1'b1;
    @(negedge ref_clk);
    `CHK("prog over debug", 1'b0, debug_serial_io_oe)
    prog_serial_drive = 1'b0;
    @(negedge ref_clk);
    `CHK("debug drive", 2'b11, {debug_serial_io_oe, debug_serial_io_out})
    {prog_serial_drive, debug_serial_drive, tool_prog, tool_dbg} = 4'h3;
    {emulation_mode, port_oe0, port_out0, prog_clock, debug_clock_in} = 5'h1F;
    repeat (4) @(negedge ref_clk);
    `CHK("prog released", 1'b0, prog_serial_io_oe)
    `CHK("prog rx", 2'b11, {prog_serial_rx, prog_clock_sync})
    `CHK("debug rx", 2'b11, {debug_serial_rx, debug_clock_sync})
    `CHK("shared off", 2'b00, port_in)
    emulation_mode = 1'b0;
    @(negedge ref_clk);
    `CHK("shared on", 2'b11, port_in)
    $display("test pins done");
  endtask : t_pins

  initial begin
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_table();
    t_map();
    t_pins();
    end_sim();
  end
endmodule : table_read_core_test
`default_nettype wire
